// ==== gtm_map.svh ====
// gtm_map.svh: register offsets, field positions, reset values of the timer
// assumes: byte addresses on an 8-bit register port, 32-bit data
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define GTM_OFF_CFG 8'h00
`define GTM_OFF_CTL 8'h04
`define GTM_OFF_LOAD_A 8'h08
`define GTM_OFF_LOAD_B 8'h0C
`define GTM_OFF_MATCH_A 8'h10
`define GTM_OFF_MATCH_B 8'h14
`define GTM_OFF_PRE_A 8'h18
`define GTM_OFF_PRE_B 8'h1C
`define GTM_OFF_VAL_A 8'h20
`define GTM_OFF_VAL_B 8'h24
`define GTM_OFF_RIS 8'h28
`define GTM_OFF_IMR 8'h2C
`define GTM_OFF_MIS 8'h30
`define GTM_OFF_LOAD_BOTH 8'h34
`define GTM_OFF_MATCH_BOTH 8'h38
`define GTM_OFF_PRE_BOTH 8'h3C
// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define GTM_CTL_A_EN 0
`define GTM_CTL_B_EN 1
`define GTM_CTL_A_STALL 2
`define GTM_CTL_B_STALL 3
`define GTM_CTL_RTC_EN 4
`define GTM_CTL_A_PWM 5
`define GTM_CTL_B_PWM 6
// ----------------------------------------------------------------------
// interrupt field positions
// ----------------------------------------------------------------------
`define GTM_INT_A_TIMEOUT 0
`define GTM_INT_A_MATCH 1
`define GTM_INT_B_TIMEOUT 2
`define GTM_INT_B_MATCH 3
`define GTM_INT_RTC_MATCH 4
// ----------------------------------------------------------------------
// reset values and 16-bit half mask
// ----------------------------------------------------------------------
`define GTM_RST_LOAD 32'h0000_0000
`define GTM_RST_MATCH 32'h0000_0000
`define GTM_RST_PRE 8'h00
`define GTM_RST_INT 5'h00
`define GTM_HALF_MASK 32'h0000_FFFF
`endif

// ==== gtm_pkg.sv ====
// gtm_pkg.sv: types shared by the timer modules
// assumes: nothing beyond a SystemVerilog compiler
package gtm_pkg;
   typedef enum logic [1:0] {GTM_CFG_32, GTM_CFG_RTC, GTM_CFG_16} gtm_cfg_t;

   typedef struct packed {
      logic run;
      logic wide;
      logic rtc;
      logic pwm;
      logic load_wr;
   } gtm_half_ctl_t;

   typedef struct packed {
      logic [31:0] count;
      logic timeout;
      logic match;
      logic pwm_out;
   } gtm_half_st_t;

   typedef struct packed {
      logic [7:0] cnt;
   } gtm_pre_st_t;

   typedef struct packed {
      gtm_cfg_t cfg;
      logic [6:0] ctl;
      logic [31:0] load_a;
      logic [15:0] load_b;
      logic [31:0] match_a;
      logic [15:0] match_b;
      logic [7:0] pre_a;
      logic [7:0] pre_b;
      logic ld_a;
      logic ld_b;
      logic [4:0] ris;
      logic [4:0] imr;
      logic [31:0] rdata;
      logic irq;
   } gtm_top_st_t;
endpackage : gtm_pkg

// ==== gtm_prescale.sv ====
// gtm_prescale.sv: 8-bit input clock prescaler of one timer half
// assumes: run and bypass come from logic on the same clock
`timescale 1ns/10ps
module gtm_prescale (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // control
   input wire logic run,
   input wire logic bypass,
   input wire logic [7:0] pre,
   // count enable to the half
   output logic tick
);
   gtm_pkg::gtm_pre_st_t st;
   gtm_pkg::gtm_pre_st_t next_st;

   always_comb begin
      next_st = st;
      tick = run && (bypass || st.cnt == pre);
      if (!run || bypass) begin
         next_st.cnt = 8'h00;
      end else if (st.cnt == pre) begin
         next_st.cnt = 8'h00;
      end else begin
         next_st.cnt = st.cnt + 8'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
endmodule : gtm_prescale

// ==== gtm_half.sv ====
// gtm_half.sv: counter of one timer half, 16-bit or joined 32-bit, or RTC
// assumes: control comes from the register file on the same clock
`timescale 1ns/10ps
`include "gtm_map.svh"
module gtm_half (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // control
   input wire gtm_pkg::gtm_half_ctl_t ctl,
   input wire logic tick,
   input wire logic [31:0] load_val,
   input wire logic [31:0] match_val,
   // state
   output gtm_pkg::gtm_half_st_t st
);
   gtm_pkg::gtm_half_st_t next_st;
   logic [31:0] mask;
   logic [31:0] dec;

   always_comb begin
      mask = ctl.wide ? 32'hFFFF_FFFF : `GTM_HALF_MASK;
      dec = (st.count - 32'h0000_0001) & mask;
      next_st = st;
      next_st.timeout = 1'b0;
      next_st.match = 1'b0;
      if (ctl.load_wr) begin
         next_st.count = load_val & mask;
      end else if (ctl.run && tick) begin
         if (ctl.rtc) begin
            next_st.count = st.count + 32'h0000_0001;
            next_st.match = (st.count + 32'h0000_0001) == match_val;
         end else if (st.count == 32'h0000_0000) begin
            next_st.count = load_val & mask;
            next_st.timeout = 1'b1;
         end else begin
            next_st.count = dec;
            next_st.match = dec == (match_val & mask);
         end
      end
      next_st.pwm_out = ctl.pwm && (st.count > (match_val & mask));
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
endmodule : gtm_half

// ==== gtm_top.sv ====
// gtm_top.sv: general timer with halves a and b, joined 32-bit, RTC, PWM
// assumes: register port master and debug halt on the same clock
//
// Operation
// - count reaching match raises match interrupt
// - match value sets half's PWM duty cycle in 16-bit mode
// - prescaler acts only in 16-bit modes
// - each half holds an 8-bit prescale
// - joined mode uses only half a registers
// - RTC enable starts counter only in RTC
// - clearing RTC enable stops the RTC counter
// - match values of both halves read back
// - live counter of either half readable
// - match and prescale writable a, b, both
// - prescale values of both halves read back
// - new load goes into counter immediately
// - stall enable halts half during debug
// - enable gates interrupt; raw status readable
`timescale 1ns/10ps
`include "gtm_map.svh"
module gtm_top (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // processor debug state
   input wire logic dbg_halt,
   // outputs
   output logic pwm_a,
   output logic pwm_b,
   output logic irq
);
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   gtm_pkg::gtm_top_st_t st;
   gtm_pkg::gtm_top_st_t next_st;
   gtm_pkg::gtm_half_ctl_t ctl_a;
   gtm_pkg::gtm_half_ctl_t ctl_b;
   gtm_pkg::gtm_half_st_t half_a;
   gtm_pkg::gtm_half_st_t half_b;
   logic tick_a;
   logic tick_b;
   logic joined;
   logic rtc_mode;
   logic [4:0] events;
   logic w_load_a;
   logic w_load_b;
   logic w_match_a;
   logic w_match_b;
   logic w_pre_a;
   logic w_pre_b;

   // ----------------------------------------------------------------------
   // half control
   // ----------------------------------------------------------------------
   always_comb begin
      rtc_mode = st.cfg == gtm_pkg::GTM_CFG_RTC;
      joined = st.cfg == gtm_pkg::GTM_CFG_32 || rtc_mode;
      ctl_a.wide = joined;
      ctl_a.rtc = rtc_mode;
      ctl_a.pwm = st.ctl[`GTM_CTL_A_PWM] && !joined;
      ctl_a.load_wr = st.ld_a;
      ctl_a.run = (rtc_mode ? st.ctl[`GTM_CTL_RTC_EN] : st.ctl[`GTM_CTL_A_EN])
         && !(st.ctl[`GTM_CTL_A_STALL] && dbg_halt);
      ctl_b.wide = 1'b0;
      ctl_b.rtc = 1'b0;
      ctl_b.pwm = st.ctl[`GTM_CTL_B_PWM] && !joined;
      ctl_b.load_wr = st.ld_b && !joined;
      ctl_b.run = !joined && st.ctl[`GTM_CTL_B_EN]
         && !(st.ctl[`GTM_CTL_B_STALL] && dbg_halt);
   end

   gtm_prescale u_pre_a (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .run(ctl_a.run),
      .bypass(joined),
      .pre(st.pre_a),
      .tick(tick_a)
   );

   gtm_prescale u_pre_b (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .run(ctl_b.run),
      .bypass(1'b0),
      .pre(st.pre_b),
      .tick(tick_b)
   );

   gtm_half u_half_a (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .ctl(ctl_a),
      .tick(tick_a),
      .load_val(st.load_a),
      .match_val(st.match_a),
      .st(half_a)
   );

   gtm_half u_half_b (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .ctl(ctl_b),
      .tick(tick_b),
      .load_val({16'h0000, st.load_b}),
      .match_val({16'h0000, st.match_b}),
      .st(half_b)
   );

   // ----------------------------------------------------------------------
   // register writes, interrupts and read port
   // ----------------------------------------------------------------------
   always_comb begin
      next_st = st;
      w_load_a = wr && (addr == `GTM_OFF_LOAD_A || addr == `GTM_OFF_LOAD_BOTH);
      w_load_b = wr && (addr == `GTM_OFF_LOAD_B || addr == `GTM_OFF_LOAD_BOTH);
      w_match_a = wr && (addr == `GTM_OFF_MATCH_A || addr == `GTM_OFF_MATCH_BOTH);
      w_match_b = wr && (addr == `GTM_OFF_MATCH_B || addr == `GTM_OFF_MATCH_BOTH);
      w_pre_a = wr && (addr == `GTM_OFF_PRE_A || addr == `GTM_OFF_PRE_BOTH);
      w_pre_b = wr && (addr == `GTM_OFF_PRE_B || addr == `GTM_OFF_PRE_BOTH);
      next_st.ld_a = w_load_a;
      next_st.ld_b = w_load_b;
      if (w_load_a) begin
         next_st.load_a = wdata;
      end
      if (w_load_b) begin
         next_st.load_b = wdata[15:0];
      end
      if (w_match_a) begin
         next_st.match_a = wdata;
      end
      if (w_match_b) begin
         next_st.match_b = wdata[15:0];
      end
      if (w_pre_a) begin
         next_st.pre_a = wdata[7:0];
      end
      if (w_pre_b) begin
         next_st.pre_b = wdata[7:0];
      end
      if (wr && addr == `GTM_OFF_CFG) begin
         case (wdata[1:0])
            2'h0: next_st.cfg = gtm_pkg::GTM_CFG_32;
            2'h1: next_st.cfg = gtm_pkg::GTM_CFG_RTC;
            default: next_st.cfg = gtm_pkg::GTM_CFG_16;
         endcase
      end
      if (wr && addr == `GTM_OFF_CTL) begin
         next_st.ctl = wdata[6:0];
         // enable is taken only in RTC mode, a clear always stops it
         next_st.ctl[`GTM_CTL_RTC_EN] = wdata[`GTM_CTL_RTC_EN]
            && (rtc_mode || st.ctl[`GTM_CTL_RTC_EN]);
      end
      if (wr && addr == `GTM_OFF_IMR) begin
         next_st.imr = wdata[4:0];
      end
      // events: set wins over a write-one clear in the same cycle
      events = 5'h00;
      events[`GTM_INT_A_TIMEOUT] = half_a.timeout;
      events[`GTM_INT_A_MATCH] = half_a.match && !rtc_mode;
      events[`GTM_INT_B_TIMEOUT] = half_b.timeout;
      events[`GTM_INT_B_MATCH] = half_b.match;
      events[`GTM_INT_RTC_MATCH] = half_a.match && rtc_mode;
      if (wr && addr == `GTM_OFF_RIS) begin
         next_st.ris = st.ris & ~wdata[4:0];
      end
      next_st.ris = next_st.ris | events;
      next_st.irq = |(next_st.ris & next_st.imr);
      next_st.rdata = 32'h0000_0000;
      if (rd) begin
         case (addr)
            `GTM_OFF_CFG: next_st.rdata = {30'h0000_0000, st.cfg};
            `GTM_OFF_CTL: next_st.rdata = {25'h000_0000, st.ctl};
            `GTM_OFF_LOAD_A: next_st.rdata = st.load_a;
            `GTM_OFF_LOAD_B: next_st.rdata = {16'h0000, st.load_b};
            `GTM_OFF_MATCH_A: next_st.rdata = st.match_a;
            `GTM_OFF_MATCH_B: next_st.rdata = {16'h0000, st.match_b};
            `GTM_OFF_PRE_A: next_st.rdata = {24'h00_0000, st.pre_a};
            `GTM_OFF_PRE_B: next_st.rdata = {24'h00_0000, st.pre_b};
            `GTM_OFF_VAL_A: next_st.rdata = half_a.count;
            `GTM_OFF_VAL_B: next_st.rdata = half_b.count;
            `GTM_OFF_RIS: next_st.rdata = {27'h000_0000, st.ris};
            `GTM_OFF_IMR: next_st.rdata = {27'h000_0000, st.imr};
            `GTM_OFF_MIS: next_st.rdata = {27'h000_0000, st.ris & st.imr};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st.cfg <= gtm_pkg::GTM_CFG_32;
         st.ctl <= 7'h00;
         st.load_a <= `GTM_RST_LOAD;
         st.load_b <= 16'h0000;
         st.match_a <= `GTM_RST_MATCH;
         st.match_b <= 16'h0000;
         st.pre_a <= `GTM_RST_PRE;
         st.pre_b <= `GTM_RST_PRE;
         st.ld_a <= 1'b0;
         st.ld_b <= 1'b0;
         st.ris <= `GTM_RST_INT;
         st.imr <= `GTM_RST_INT;
         st.rdata <= 32'h0000_0000;
         st.irq <= 1'b0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign rdata = st.rdata;
   assign irq = st.irq;
   assign pwm_a = half_a.pwm_out;
   assign pwm_b = half_b.pwm_out;
endmodule : gtm_top

// ==== gtm_top_asserts.sv ====
// gtm_top_asserts.sv: port checker of the general timer, bound to gtm_top
// assumes: register map of gtm_map.svh, one clock, async active-low reset
`timescale 1ns/10ps
`include "gtm_map.svh"
module gtm_top_chk (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // debug and interrupt
   input wire logic dbg_halt,
   input wire logic irq
);
   // ---------------------------------------------------------------
   // shadow of mode and control
   // ---------------------------------------------------------------
   logic [1:0] cfg;
   logic [6:0] ctl;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= 2'h0;
         ctl <= 7'h00;
      end else if (wr && ce && addr == `GTM_OFF_CFG) begin
         cfg <= wdata[1:0];
      end else if (wr && ce && addr == `GTM_OFF_CTL) begin
         ctl <= wdata[6:0];
         ctl[4] <= wdata[4] && (cfg == 2'h1 || ctl[4]);
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_val_pair;
      rd && ce && addr == `GTM_OFF_VAL_A ##1 rd && ce && addr == `GTM_OFF_VAL_A;
   endsequence
   sequence s_wr_rd(logic [7:0] a);
      wr && ce && addr == a ##1 rd && ce && addr == a;
   endsequence
   chk_read_quiet: assert property (ce && !rd |=> rdata == 32'h0)
      else $error("read data not cleared");
   chk_match_back: assert property (
      s_wr_rd(`GTM_OFF_MATCH_A) |=> rdata == $past(wdata, 2))
      else $error("match value not read back");
   chk_pre_back: assert property (
      s_wr_rd(`GTM_OFF_PRE_A) |=> rdata == ($past(wdata, 2) & 32'h0000_00FF))
      else $error("prescale not read back");
   chk_mask_gate: assert property (
      wr && ce && addr == `GTM_OFF_IMR && wdata[4:0] == 5'h00 |=> ##1 !irq)
      else $error("masked interrupt reached irq");
   chk_rtc_ignored: assert property (
      (wr && ce && addr == `GTM_OFF_CTL && wdata[4] && cfg != 2'h1 && !ctl[4])
      ##1 (rd && ce && addr == `GTM_OFF_CTL) |=> !rdata[4])
      else $error("rtc enable taken outside rtc mode");
   chk_rtc_runs: assert property (
      (cfg == 2'h1 && ctl[4] && $past(ctl[4]) && !ctl[2]) ##0 s_val_pair
      |=> rdata == $past(rdata) + 32'h1)
      else $error("rtc counter not advancing");
   chk_rtc_stops: assert property (
      (cfg == 2'h1 && !ctl[4] && !$past(ctl[4]) && !ctl[0]) ##0 s_val_pair
      |=> $stable(rdata))
      else $error("rtc counter moved while stopped");
   chk_stall_hold: assert property (
      (ctl[2] && $past(ctl[2]) && dbg_halt && $past(dbg_halt)) ##0 s_val_pair
      ##0 dbg_halt |=> $stable(rdata))
      else $error("half counted during debug stall");
endmodule : gtm_top_chk
bind gtm_top gtm_top_chk chk (.clock(clock), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .dbg_halt(dbg_halt), .irq(irq));

// ==== gtm_top_tb.sv ====
// gtm_top_tb.sv: self-checking bench of the general timer
// assumes: gtm_top with its checker bound, register map of gtm_map.svh
`timescale 1ns/10ps
`include "gtm_map.svh"
module gtm_top_tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic dbg_halt = 1'b0;
   logic [31:0] rdata;
   logic pwm_a;
   logic pwm_b;
   logic irq;
   logic [31:0] d0;
   logic [31:0] d1;
   logic [31:0] d2;
   int error_cnt = 0;
   int checks = 0;
   int n;
   time t;
   int pre_tab[4] = '{3, 0, 3, 255};
   int ld_tab[4] = '{4, 4, 4, 1};
   int per_tab[4] = '{5, 5, 20, 512};
   gtm_top uut (.clock(clock), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .dbg_halt(dbg_halt), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq));
   always #25 clock = ~clock;
   // ---------------------------------------------------------------
   // access and compare tasks
   // ---------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
   endtask : wr_reg
   task rd2(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      @(negedge clock);
      d0 = rdata;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      d1 = rdata;
   endtask : rd2
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd2(a);
      check(d0, exp);
   endtask : rdchk
   task wait_irq;
      int k;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (irq !== 1'b1 && k < 3000);
      check(irq, 1'b1);
   endtask : wait_irq
   task conclude;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      #2_000_000;
      error_cnt++;
      conclude;
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      for (int a = 0; a <= 64; a += 4) begin
         if (a < 52 || a == 64) begin
            rdchk(8'(a), 32'h0);
         end
      end
      $display("test reset values done");
      wr_reg(`GTM_OFF_MATCH_BOTH, 32'h0000_1234);
      wr_reg(`GTM_OFF_PRE_BOTH, 32'h0000_00FF);
      rdchk(`GTM_OFF_MATCH_A, 32'h0000_1234);
      rdchk(`GTM_OFF_MATCH_B, 32'h0000_1234);
      rdchk(`GTM_OFF_PRE_A, 32'h0000_00FF);
      rdchk(`GTM_OFF_PRE_B, 32'h0000_00FF);
      wr_reg(`GTM_OFF_MATCH_B, 32'h0000_BEEF);
      wr_reg(`GTM_OFF_MATCH_A, 32'hCAFE_0001);
      wr_reg(`GTM_OFF_PRE_B, 32'h0000_0000);
      rdchk(`GTM_OFF_MATCH_B, 32'h0000_BEEF);
      rdchk(`GTM_OFF_MATCH_A, 32'hCAFE_0001);
      rdchk(`GTM_OFF_PRE_A, 32'h0000_00FF);
      $display("test match and prescale done");
      for (int i = 0; i < 4; i++) begin
         wr_reg(`GTM_OFF_CTL, 32'h0);
         wr_reg(`GTM_OFF_RIS, 32'h1F);
         wr_reg(`GTM_OFF_CFG, (i == 0) ? 32'h0 : 32'h2);
         wr_reg(`GTM_OFF_PRE_A, pre_tab[i]);
         wr_reg(`GTM_OFF_LOAD_A, ld_tab[i]);
         wr_reg(`GTM_OFF_IMR, 32'h1);
         wr_reg(`GTM_OFF_CTL, 32'h1);
         wait_irq;
         t = $time;
         wr_reg(`GTM_OFF_RIS, 32'h1F);
         wait_irq;
         check(32'(($time - t) / 50), per_tab[i]);
      end
      wr_reg(`GTM_OFF_IMR, 32'h0);
      @(negedge clock);
      check(irq, 1'b0);
      rd2(`GTM_OFF_RIS);
      check(d0 & 32'h1, 32'h1);
      rdchk(`GTM_OFF_MIS, 32'h0);
      $display("test prescale period done");
      wr_reg(`GTM_OFF_CTL, 32'h0);
      wr_reg(`GTM_OFF_RIS, 32'h1F);
      wr_reg(`GTM_OFF_PRE_A, 32'h0);
      wr_reg(`GTM_OFF_MATCH_A, 32'h5);
      wr_reg(`GTM_OFF_LOAD_A, 32'hA);
      wr_reg(`GTM_OFF_LOAD_B, 32'hC000);
      wr_reg(`GTM_OFF_IMR, 32'h2);
      wr_reg(`GTM_OFF_CTL, 32'h61);
      wait_irq;
      rd2(`GTM_OFF_RIS);
      check(d0 & 32'h2, 32'h2);
      n = 0;
      repeat (22) begin
         @(negedge clock);
         if (pwm_a === 1'b1) n++;
      end
      check(n, 10);
      check(pwm_b, 1'b1);
      $display("test match and pwm done");
      wr_reg(`GTM_OFF_CTL, 32'h0);
      wr_reg(`GTM_OFF_CFG, 32'h0);
      wr_reg(`GTM_OFF_CTL, 32'h41);
      @(negedge clock);
      check(pwm_b, 1'b0);
      wr_reg(`GTM_OFF_LOAD_A, 32'h0001_0000);
      rd2(`GTM_OFF_VAL_A);
      check((32'h0001_0000 - d0) < 8, 1'b1);
      wr_reg(`GTM_OFF_CTL, 32'h5);
      @(posedge clock) dbg_halt <= 1'b1;
      rd2(`GTM_OFF_VAL_A);
      check(d1, d0);
      wr_reg(`GTM_OFF_CTL, 32'h1);
      rd2(`GTM_OFF_VAL_A);
      check(d0 - d1, 32'h1);
      @(posedge clock) dbg_halt <= 1'b0;
      $display("test load and stall done");
      wr_reg(`GTM_OFF_CTL, 32'h10);
      rd2(`GTM_OFF_CTL);
      check(d0[4], 1'b0);
      wr_reg(`GTM_OFF_MATCH_A, 32'h00FF_FFFF);
      wr_reg(`GTM_OFF_CFG, 32'h1);
      wr_reg(`GTM_OFF_CTL, 32'h10);
      rd2(`GTM_OFF_VAL_A);
      check(d1 - d0, 32'h1);
      d2 = d1;
      @(posedge clock) ce <= 1'b0;
      repeat (10) @(posedge clock);
      ce <= 1'b1;
      rd2(`GTM_OFF_VAL_A);
      check(d0 - d2, 32'h3);
      wr_reg(`GTM_OFF_CTL, 32'h0);
      rd2(`GTM_OFF_VAL_A);
      check(d1, d0);
      $display("test rtc done");
      conclude;
   end
endmodule : gtm_top_tb
